// >>> pkg/ptd_defs.vh
`ifndef PTD_DEFS_VH
`define PTD_DEFS_VH

// sample and accumulator widths
`define PTD_SAMPLE_W 16
`define PTD_PHASE_W 32
`define PTD_LUT_PHASE_W 12
`define PTD_IIR_FRAC_W 16

// sine quarter table: 32 segments of 32 steps each
`define PTD_SEG_BITS 5
`define PTD_SINE_PEAK 16'h7fff

// dither lands below the 12 bits used for the table
`define PTD_DITHER_BITS 20
`define PTD_LFSR_TAPS 32'h80200003

// low-pass shift per filter selector 0..3
`define PTD_IIR_SHIFT_0 5'h06
`define PTD_IIR_SHIFT_1 5'h05
`define PTD_IIR_SHIFT_2 5'h04
`define PTD_IIR_SHIFT_3 5'h03

// settling figures in samples per filter selector
`define PTD_SETTLE_0 300
`define PTD_SETTLE_1 150
`define PTD_SETTLE_2 75
`define PTD_SETTLE_3 50

// register port word indexes
`define PTD_ADDR_W 2
`define PTD_REG_STATUS 2'h0
`define PTD_REG_MASK 2'h1
`define PTD_REG_LEVEL 2'h2
`define PTD_REG_PHASE 2'h3

// status and mask fields
`define PTD_EV_W 2
`define PTD_EV_RISE 0
`define PTD_EV_FALL 1
`define PTD_LEVEL_TONE 16

// reset values
`define PTD_STATUS_RST 2'h0
`define PTD_MASK_RST 2'h0
`define PTD_RDATA_RST 32'h00000000

`endif

// >>> verilog/ptd_lowpass.v
`timescale 1ns/1ps
`include "ptd_defs.vh"
// two cascaded one-pole sections; shift sets the bandwidth
module ptd_lowpass (
  input wire clk_in,
  input wire reset_n_in,
  input wire en_in,
  input wire [4:0] shift_in,
  input wire signed [15:0] x_in,
  output wire signed [15:0] y_out
);
  localparam ST_W = `PTD_SAMPLE_W + `PTD_IIR_FRAC_W + 2;

  reg signed [ST_W-1:0] s1_r;
  reg signed [ST_W-1:0] s2_r;
  wire signed [ST_W-1:0] x_ext;
  wire signed [ST_W-1:0] s1_nxt;
  wire signed [ST_W-1:0] s2_nxt;

  // input scaled into the fractional state format
  assign x_ext = {{2{x_in[15]}}, x_in, {`PTD_IIR_FRAC_W{1'b0}}};
  // y += (x - y) / 2^shift, the recursive form keeps it to adders
  assign s1_nxt = s1_r + ((x_ext - s1_r) >>> shift_in);
  assign s2_nxt = s2_r + ((s1_r - s2_r) >>> shift_in);

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s1_r <= {ST_W{1'b0}};
      s2_r <= {ST_W{1'b0}};
    end else if (en_in) begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end

  // state never exceeds the input range, so no saturation needed
  assign y_out = s2_r[`PTD_IIR_FRAC_W+15:`PTD_IIR_FRAC_W];
endmodule // ptd_lowpass

// >>> verilog/ptd_detector.v
`timescale 1ns/1ps
// Notes on behaviour
// - 32-bit phase increment accumulated each sample
// - sine and cosine from 12-bit phase
// - optional seeded pseudo-random phase dither
// - build choice of complex or real input
// - mix samples to baseband before filtering
// - filtered I and Q out, 16-bit signed
// - two matching recursive low-pass filters
// - selector 0..3 picks four cutoffs
// - narrower filter settles slower, 300 to 50
// - magnitude is power of filtered I, Q
// - flag raised once magnitude exceeds threshold
// - gain setting scales by 1,2,4,8
// - frequencies from Fs/2^32 to Fs/2
// - advance only on clock with enable high
// - flag high while magnitude exceeds threshold
`include "ptd_defs.vh"

module ptd_detector #(
  parameter [1:0] GAIN = 2'h0,
  parameter DITHER = 1,
  parameter [31:0] SEED = 32'h00000001,
  parameter USE_COMPLEX = 1,
  parameter [1:0] FILTER_TYPE = 2'h0,
  parameter [15:0] THRESHOLD = 16'h0400
) (
  input wire clk_in,
  input wire reset_n_in,
  input wire en_in,
  input wire [31:0] phase_inc_in,
  input wire signed [15:0] i_in,
  input wire signed [15:0] q_in,
  input wire [1:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output wire [31:0] rdata_out,
  output wire signed [15:0] i_out,
  output wire signed [15:0] q_out,
  output wire [15:0] mag_out,
  output wire tone_present_out,
  output wire irq_out
);

  // quarter sine table, entry k = peak * sin(k * pi / 64)
  function [15:0] ptd_quarter;
    input [5:0] k;
    begin
      case (k)
        6'd0: ptd_quarter = 16'h0000;
        6'd1: ptd_quarter = 16'h0648;
        6'd2: ptd_quarter = 16'h0c8c;
        6'd3: ptd_quarter = 16'h12c8;
        6'd4: ptd_quarter = 16'h18f9;
        6'd5: ptd_quarter = 16'h1f1a;
        6'd6: ptd_quarter = 16'h2528;
        6'd7: ptd_quarter = 16'h2b1f;
        6'd8: ptd_quarter = 16'h30fb;
        6'd9: ptd_quarter = 16'h36ba;
        6'd10: ptd_quarter = 16'h3c57;
        6'd11: ptd_quarter = 16'h41ce;
        6'd12: ptd_quarter = 16'h471d;
        6'd13: ptd_quarter = 16'h4c40;
        6'd14: ptd_quarter = 16'h5133;
        6'd15: ptd_quarter = 16'h55f5;
        6'd16: ptd_quarter = 16'h5a82;
        6'd17: ptd_quarter = 16'h5ed7;
        6'd18: ptd_quarter = 16'h62f2;
        6'd19: ptd_quarter = 16'h66cf;
        6'd20: ptd_quarter = 16'h6a6d;
        6'd21: ptd_quarter = 16'h6dca;
        6'd22: ptd_quarter = 16'h70e2;
        6'd23: ptd_quarter = 16'h73b5;
        6'd24: ptd_quarter = 16'h7641;
        6'd25: ptd_quarter = 16'h7884;
        6'd26: ptd_quarter = 16'h7a7d;
        6'd27: ptd_quarter = 16'h7c29;
        6'd28: ptd_quarter = 16'h7d8a;
        6'd29: ptd_quarter = 16'h7e9d;
        6'd30: ptd_quarter = 16'h7f62;
        6'd31: ptd_quarter = 16'h7fd8;
        default: ptd_quarter = `PTD_SINE_PEAK;
      endcase
    end
  endfunction

  // sine of a 12-bit phase; table plus linear interpolation
  function signed [15:0] ptd_sine;
    input [11:0] ph;
    reg [10:0] f;
    reg [15:0] lo;
    reg [15:0] hi;
    reg [20:0] step;
    reg [15:0] mag;
    begin
      f = {1'b0, ph[9:0]};
      lo = 16'h0000;
      hi = 16'h0000;
      step = 21'h000000;
      mag = 16'h0000;
      // mirror in the second and fourth quadrants
      if (ph[10]) begin
        f = 11'h400 - f;
      end
      lo = ptd_quarter(f[10:5]);
      hi = ptd_quarter(f[10:5] + 6'd1);
      step = (hi - lo) * f[4:0];
      mag = lo + step[20:5];
      // negative half cycle
      if (ph[11]) begin
        ptd_sine = -$signed(mag);
      end else begin
        ptd_sine = $signed(mag);
      end
    end
  endfunction

  // clamp a wide signed value into 16 bits
  function signed [15:0] ptd_sat16;
    input signed [35:0] v;
    begin
      if (v > 36'sh0_0000_7fff) begin
        ptd_sat16 = 16'sh7fff;
      end else if (v < -36'sh0_0000_8000) begin
        ptd_sat16 = 16'sh8000;
      end else begin
        ptd_sat16 = v[15:0];
      end
    end
  endfunction

  // filter shift for the build-time selector
  function [4:0] ptd_shift;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: ptd_shift = `PTD_IIR_SHIFT_0;
        2'h1: ptd_shift = `PTD_IIR_SHIFT_1;
        2'h2: ptd_shift = `PTD_IIR_SHIFT_2;
        default: ptd_shift = `PTD_IIR_SHIFT_3;
      endcase
    end
  endfunction

  // oscillator and input capture stage
  reg [31:0] acc_r;
  reg [31:0] lfsr_r;
  reg [11:0] lut_ph_r;
  reg signed [15:0] i_s1_r;
  reg signed [15:0] q_s1_r;
  reg signed [15:0] cos_r;
  reg signed [15:0] sin_r;
  reg signed [15:0] i_s2_r;
  reg signed [15:0] q_s2_r;
  reg signed [15:0] bb_i_r;
  reg signed [15:0] bb_q_r;
  reg [15:0] mag_r;
  reg tone_r;
  reg [1:0] status_r;
  reg [1:0] mask_r;
  reg irq_r;
  reg [31:0] rdata_r;

  wire [31:0] acc_nxt;
  wire [31:0] lfsr_nxt;
  wire [31:0] dith_ph;
  wire signed [15:0] q_used;
  wire signed [31:0] p_ic;
  wire signed [31:0] p_qs;
  wire signed [31:0] p_qc;
  wire signed [31:0] p_is;
  wire signed [35:0] mix_i;
  wire signed [35:0] mix_q;
  wire signed [15:0] filt_i;
  wire signed [15:0] filt_q;
  wire [31:0] pwr_i;
  wire [31:0] pwr_q;
  wire [32:0] pwr;
  wire [15:0] mag_nxt;
  wire tone_nxt;
  wire [1:0] ev;
  wire [1:0] clr;
  wire [1:0] status_nxt;
  wire [1:0] mask_nxt;
  wire [4:0] lp_shift;

  // phase wraps modulo 2^32, step is Fs/2^32
  // increment up to half range gives Fs/2
  assign acc_nxt = acc_r + phase_inc_in;

  // galois shift register, never reaches zero
  assign lfsr_nxt = lfsr_r[0] ? ((lfsr_r >> 1) ^ `PTD_LFSR_TAPS)
                              : (lfsr_r >> 1);

  // dither is added below the table phase and reaches it only by carry
  assign dith_ph = DITHER ? (acc_r +
                   {12'h000, lfsr_r[`PTD_DITHER_BITS-1:0]}) : acc_r;

  // real mode ignores the quadrature input
  assign q_used = USE_COMPLEX ? q_in : 16'sh0000;

  // everything holds while enable is low
  // async clear, generator reloads its seed
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_r <= 32'h00000000;
      lfsr_r <= SEED;
      lut_ph_r <= 12'h000;
      i_s1_r <= 16'sh0000;
      q_s1_r <= 16'sh0000;
    end else if (en_in) begin
      acc_r <= acc_nxt;
      lfsr_r <= lfsr_nxt;
      // top 12 bits address the sine table
      lut_ph_r <= dith_ph[31:20];
      i_s1_r <= i_in;
      q_s1_r <= q_used;
    end
  end

  // sine and cosine stage; cosine leads by a quarter turn
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cos_r <= 16'sh0000;
      sin_r <= 16'sh0000;
      i_s2_r <= 16'sh0000;
      q_s2_r <= 16'sh0000;
    end else if (en_in) begin
      // both outputs from the 12-bit phase
      cos_r <= ptd_sine(lut_ph_r + 12'h400);
      sin_r <= ptd_sine(lut_ph_r);
      i_s2_r <= i_s1_r;
      q_s2_r <= q_s1_r;
    end
  end

  // complex multiply by the conjugate oscillator
  assign p_ic = i_s2_r * cos_r;
  assign p_qs = q_s2_r * sin_r;
  assign p_qc = q_s2_r * cos_r;
  assign p_is = i_s2_r * sin_r;

  // shift tone to baseband before the filters
  // gain shift before rescaling by 2^15
  // a concatenation is unsigned, so cast back or >>> loses the sign
  assign mix_i = ($signed({{4{p_ic[31]}}, p_ic} + {{4{p_qs[31]}}, p_qs})
                  <<< GAIN) >>> 15;
  assign mix_q = ($signed({{4{p_qc[31]}}, p_qc} - {{4{p_is[31]}}, p_is})
                  <<< GAIN) >>> 15;

  // mixer register, saturated so gain cannot wrap
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bb_i_r <= 16'sh0000;
      bb_q_r <= 16'sh0000;
    end else if (en_in) begin
      bb_i_r <= ptd_sat16(mix_i);
      bb_q_r <= ptd_sat16(mix_q);
    end
  end

  // smaller shift settles in fewer samples
  assign lp_shift = ptd_shift(FILTER_TYPE);

  ptd_lowpass u_lp_i (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .en_in(en_in),
    .shift_in(lp_shift),
    .x_in(bb_i_r),
    .y_out(filt_i)
  );

  ptd_lowpass u_lp_q (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .en_in(en_in),
    .shift_in(lp_shift),
    .x_in(bb_q_r),
    .y_out(filt_q)
  );

  // power i^2 + q^2, top 16 bits kept
  assign pwr_i = filt_i * filt_i;
  assign pwr_q = filt_q * filt_q;
  assign pwr = {1'b0, pwr_i} + {1'b0, pwr_q};
  // both squares stay at or below 2^30, so bit 32 stays clear
  assign mag_nxt = pwr[31:16];

  // threshold compare on the new magnitude
  assign tone_nxt = (mag_nxt > THRESHOLD);

  // magnitude and flag registered together to stay aligned
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mag_r <= 16'h0000;
      tone_r <= 1'b0;
    end else if (en_in) begin
      mag_r <= mag_nxt;
      tone_r <= tone_nxt;
    end
  end

  // flag edges as interrupt events
  assign ev[`PTD_EV_RISE] = en_in & tone_nxt & ~tone_r;
  assign ev[`PTD_EV_FALL] = en_in & ~tone_nxt & tone_r;

  // write-one-to-clear; a new event beats the clear
  assign clr = (wr_in && addr_in == `PTD_REG_STATUS) ?
               wdata_in[1:0] : 2'h0;
  assign status_nxt = (status_r & ~clr) | ev;
  assign mask_nxt = (wr_in && addr_in == `PTD_REG_MASK) ?
                    wdata_in[1:0] : mask_r;

  // status, mask and interrupt line; irq follows the next state
  // so it is a flop yet never lags the status bits
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_r <= `PTD_STATUS_RST;
      mask_r <= `PTD_MASK_RST;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      irq_r <= |(status_nxt & mask_nxt);
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_r <= `PTD_RDATA_RST;
    end else if (rd_in) begin
      case (addr_in)
        `PTD_REG_STATUS: rdata_r <= {30'h00000000, status_r};
        `PTD_REG_MASK: rdata_r <= {30'h00000000, mask_r};
        `PTD_REG_LEVEL: rdata_r <= {15'h0000, tone_r, mag_r};
        `PTD_REG_PHASE: rdata_r <= acc_r;
        default: rdata_r <= `PTD_RDATA_RST;
      endcase
    end else begin
      rdata_r <= `PTD_RDATA_RST;
    end
  end

  // filtered baseband straight from filter state
  assign i_out = filt_i;
  assign q_out = filt_q;
  assign mag_out = mag_r;
  assign tone_present_out = tone_r;
  assign irq_out = irq_r;
  assign rdata_out = rdata_r;

endmodule // ptd_detector

// >>> test/ptd_tone_src.sv
`timescale 1ns/1ps
// upstream tone source: one complex sample per enabled edge
module ptd_tone_src (
  input wire clk_in,
  input wire en_in,
  input wire [31:0] inc_in,
  output logic signed [15:0] i_out,
  output logic signed [15:0] q_out
);
  logic [31:0] acc_r = 32'h0;
  real ang;
  initial begin
    i_out = 16'sh0;
    q_out = 16'sh0;
  end
  always @(posedge clk_in) begin
    if (en_in) begin
      ang = 6.283185307 * acc_r / 4294967296.0;
      i_out <= 16'($rtoi(30000.0 * $cos(ang)));
      q_out <= 16'($rtoi(30000.0 * $sin(ang)));
      acc_r <= acc_r + inc_in;
    end
  end
endmodule // ptd_tone_src

// >>> test/ptd_detector_assertions.sv
`timescale 1ns/1ps
module ptd_checker #(
  parameter [15:0] THRESHOLD = 16'h0400
) (
  input wire clk_in,
  input wire reset_n_in,
  input wire en_in,
  input wire [31:0] phase_inc_in,
  input wire [1:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [31:0] rdata_out,
  input wire signed [15:0] i_out,
  input wire signed [15:0] q_out,
  input wire [15:0] mag_out,
  input wire tone_present_out,
  input wire irq_out
);
  // power of the filter outputs, lands in mag_out one sample later
  wire [32:0] pow_w;
  wire [15:0] pow_hi;
  assign pow_w = i_out * i_out + q_out * q_out;
  assign pow_hi = pow_w[31:16];
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_flag;
    tone_present_out == (mag_out > THRESHOLD);
  endproperty
  a_flag: assert property (p_flag)
    else $error("flag disagrees with magnitude");
  property p_hold;
    !en_in |=> $stable(i_out) && $stable(q_out) && $stable(mag_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("outputs moved with enable low");
  property p_mag;
    en_in |=> mag_out == $past(pow_hi);
  endproperty
  a_mag: assert property (p_mag)
    else $error("magnitude is not the power of I and Q");
  property p_level;
    rd_in && addr_in == 2'h2 |=>
      rdata_out == {15'h0, $past(tone_present_out), $past(mag_out)};
  endproperty
  a_level: assert property (p_level)
    else $error("level read does not match outputs");
  property p_idle;
    !rd_in |=> rdata_out == 32'h0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("read data outside read cycle");
  // accumulator moves by the increment only on enabled edges
  property p_phase;
    rd_in && addr_in == 2'h3 ##1 rd_in && addr_in == 2'h3 |=>
      rdata_out == $past(rdata_out) +
      ($past(en_in, 2) ? $past(phase_inc_in, 2) : 32'h0);
  endproperty
  a_phase: assert property (p_phase)
    else $error("phase accumulator step wrong");
  property p_mask;
    wr_in && addr_in == 2'h1 ##1 rd_in && addr_in == 2'h1 |=>
      rdata_out == ($past(wdata_in, 2) & 32'h3);
  endproperty
  a_mask: assert property (p_mask)
    else $error("mask read back wrong");
  property p_irq_off;
    wr_in && addr_in == 2'h1 && wdata_in[1:0] == 2'h0 |=> !irq_out;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt high with all masked");
  property p_rst;
    $rose(reset_n_in) |-> !irq_out && !tone_present_out &&
      mag_out == 16'h0 && i_out == 16'sh0 && q_out == 16'sh0;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not cleared by reset");
  c_rise: cover property ($rose(tone_present_out));
  c_fall: cover property ($fell(tone_present_out));
  c_irq: cover property ($rose(irq_out));
endmodule // ptd_checker

bind ptd_detector ptd_checker #(.THRESHOLD(THRESHOLD)) chk_u (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .en_in(en_in),
  .phase_inc_in(phase_inc_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .i_out(i_out),
  .q_out(q_out), .mag_out(mag_out), .tone_present_out(tone_present_out),
  .irq_out(irq_out)
);

// >>> test/ptd_detector_tb.sv
`timescale 1ns/1ps
`include "ptd_defs.vh"
module ptd_detector_tb;
  // tone at a sixteenth and three sixteenths of the sample rate
  localparam [31:0] INC_ON = 32'h10000000;
  localparam [31:0] INC_OFF = 32'h30000000;
  logic clk_in, reset_n_in, en_in, wr_in, rd_in;
  logic [31:0] phase_inc_in, wdata_in, src_inc, q, keep;
  logic [1:0] addr_in;
  wire [31:0] rdata_out;
  wire signed [15:0] i_in, q_in, i_out, q_out;
  wire [15:0] mag_out;
  wire tone_present_out, irq_out;
  wire signed [15:0] half_i, neg_q;
  wire [15:0] r_mag;
  wire r_tone;
  // half-scale tone for the gain x2 twin; q carries a mirrored tone
  assign half_i = i_in >>> 1;
  assign neg_q = -q_in;
  int mismatches = 0;
  int num_checks = 0;

  ptd_detector dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .en_in(en_in), .phase_inc_in(phase_inc_in), .i_in(i_in), .q_in(q_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .i_out(i_out), .q_out(q_out),
    .mag_out(mag_out), .tone_present_out(tone_present_out),
    .irq_out(irq_out));
  ptd_tone_src src_u (.clk_in(clk_in), .en_in(en_in), .inc_in(src_inc),
    .i_out(i_in), .q_out(q_in));
  // real-mode twin: if it used q, the mirrored tone would upset it
  ptd_detector #(.GAIN(2'h1), .DITHER(0), .USE_COMPLEX(0),
    .FILTER_TYPE(2'h1)) dut_real_u (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .en_in(en_in), .phase_inc_in(phase_inc_in),
    .i_in(half_i), .q_in(neg_q), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(), .i_out(), .q_out(),
    .mag_out(r_mag), .tone_present_out(r_tone), .irq_out());

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // optional write or read, then a back-to-back read of a1
  task bus(input logic w0, input logic [1:0] a0, input logic [31:0] d,
           input logic [1:0] a1);
    @(posedge clk_in);
    wr_in <= w0;
    rd_in <= !w0;
    addr_in <= a0;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    addr_in <= a1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    q = rdata_out;
  endtask

  task settle;
    repeat (600) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  task t_reset;
    chk("mag", 32'h0, {16'h0, mag_out});
    chk("irq", 32'h0, {31'h0, irq_out});
    bus(1'b1, `PTD_REG_MASK, 32'h0, `PTD_REG_STATUS);
    chk("status", 32'h0, q);
  endtask

  task t_tone;
    @(posedge clk_in);
    en_in <= 1'b1;
    settle;
    chk("tone_on", 32'h1, {31'h0, tone_present_out});
    chk("real_tone", 32'h1, {31'h0, r_tone});
    // 15000 amplitude at baseband gives near 0x0d69
    chk("real_gain", 32'h1,
        {31'h0, r_mag > 16'h0c00 && r_mag < 16'h0e00});
    bus(1'b0, `PTD_REG_PHASE, 32'h0, `PTD_REG_LEVEL);
    chk("level_hi", 32'h1, {31'h0, q[15:0] > 16'h0400});
    bus(1'b1, `PTD_REG_MASK, 32'h0, `PTD_REG_STATUS);
    chk("status_rise", 32'h1, q);
    chk("irq_masked", 32'h0, {31'h0, irq_out});
  endtask

  task t_irq;
    bus(1'b1, `PTD_REG_MASK, 32'h1, `PTD_REG_MASK);
    chk("irq_on", 32'h1, {31'h0, irq_out});
    bus(1'b1, `PTD_REG_STATUS, 32'h1, `PTD_REG_STATUS);
    chk("status_clr", 32'h0, q);
    chk("irq_clr", 32'h0, {31'h0, irq_out});
  endtask

  task t_hold;
    @(posedge clk_in);
    en_in <= 1'b0;
    @(negedge clk_in);
    keep = {mag_out, i_out};
    bus(1'b0, `PTD_REG_PHASE, 32'h0, `PTD_REG_PHASE);
    chk("hold", keep, {mag_out, i_out});
    @(posedge clk_in);
    en_in <= 1'b1;
    bus(1'b0, `PTD_REG_PHASE, 32'h0, `PTD_REG_PHASE);
  endtask

  task t_off;
    bus(1'b1, `PTD_REG_MASK, 32'h3, `PTD_REG_LEVEL);
    @(posedge clk_in);
    src_inc <= INC_OFF;
    settle;
    chk("tone_off", 32'h0, {31'h0, tone_present_out});
    chk("real_off", 32'h0, {31'h0, r_tone});
    chk("irq_fall", 32'h1, {31'h0, irq_out});
    bus(1'b0, `PTD_REG_LEVEL, 32'h0, `PTD_REG_STATUS);
    chk("status_fall", 32'h2, q);
  endtask

  // reset dropped mid-run must clear without a clock edge
  task t_async;
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    #2;
    chk("rst_out", 32'h0, {mag_out, i_out});
    chk("rst_irq", 32'h0, {31'h0, irq_out});
    @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    reset_n_in = 1'b0;
    en_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 2'h0;
    wdata_in = 32'h0;
    // exact increment for the wanted tone
    phase_inc_in = INC_ON;
    src_inc = INC_ON;
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(negedge clk_in);
    t_reset;
    t_tone;
    t_irq;
    t_hold;
    t_off;
    t_async;
    print_verdict;
  end

  // whole run is near 1250 cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    print_verdict;
  end
endmodule // ptd_detector_tb
